// ===== design/sbc_pkg.sv
// Package of constants for the SR-IOV BAR and capability configuration block
package sbc_pkg;
   // BAR type selector values
   localparam logic [1:0] BAR_TYPE_NONE = 2'h0;
   localparam logic [1:0] BAR_TYPE_MEM = 2'h1;
   localparam logic [1:0] BAR_TYPE_IO = 2'h2;
   // Aperture limits as log2 of the size in bytes
   localparam logic [5:0] MIN_LOG2_NORMAL = 6'h07;
   localparam logic [5:0] MIN_LOG2_LEGACY = 6'h04;
   localparam logic [5:0] MIN_LOG2_IO = 6'h04;
   localparam logic [5:0] MAX_LOG2_32 = 6'h1F;
   localparam logic [5:0] MAX_LOG2_64 = 6'h3F;
   // BAR index that is exempt from the prefetchable 64-bit demand
   localparam int LAST_BAR = 5;
   localparam int NUM_BARS = 6;
   // Extended capability offsets
   localparam logic [11:0] AER_OFFSET = 12'h100;
   localparam logic [11:0] EXT_CAP_STRIDE = 12'h040;
   localparam int NUM_EXT_CAPS = 7;
   // Power state indices D0, D1, D2, D3hot, D3cold
   localparam int NUM_PSTATES = 5;
   localparam int PSTATE_D1 = 1;
   // Reset value of every BAR base register
   localparam logic [31:0] BAR_RESET = 32'h0000_0000;
endpackage

// ===== design/sbc_bar_decode.sv
// Address decoder for one base address register slot
module sbc_bar_decode
(
   input wire logic [1:0] bar_type,
   input wire logic usable,
   input wire logic is64,
   input wire logic [5:0] log2_size,
   input wire logic [63:0] base,
   input wire logic [63:0] req_addr,
   input wire logic req_is_io,
   input wire logic req_valid,
   output logic hit,
   output logic [63:0] offset
);
   logic [63:0] mask;
   logic type_ok;
   // Low bits below the aperture size, and bits 63:32 for a 32-bit window, are the offset inside the window
   always_comb
   begin
      mask = (64'h0000_0000_0000_0001 << log2_size) - 64'h0000_0000_0000_0001;
      if (!is64)
      begin
         mask = mask | 64'hFFFF_FFFF_0000_0000;
      end
      type_ok = req_is_io ? (bar_type == sbc_pkg::BAR_TYPE_IO)
                          : (bar_type == sbc_pkg::BAR_TYPE_MEM);
      hit = req_valid && usable && type_ok
            && ((req_addr & ~mask) == (base & ~mask));
      offset = req_addr & mask;
   end
endmodule

// ===== design/sbc_core.sv
// SR-IOV BAR legality, decoding, MSI-X placement, power and capability list
module sbc_core
#(
   parameter int NUM_BAR = 6,
   parameter int NUM_CAP = 7
)
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic legacy_ep,
   input wire logic [11:0] bar_type_cfg,
   input wire logic [5:0] bar_is64_cfg,
   input wire logic [5:0] bar_pref_cfg,
   input wire logic [35:0] bar_log2_cfg,
   input wire logic bar_wr,
   input wire logic [2:0] bar_wr_idx,
   input wire logic [31:0] bar_wr_data,
   input wire logic [2:0] bar_rd_idx,
   output logic [31:0] bar_rd_data,
   output logic [5:0] bar_legal,
   input wire logic req_valid,
   input wire logic req_is_io,
   input wire logic [63:0] req_addr,
   output logic req_hit,
   output logic [2:0] req_bar,
   output logic [63:0] req_offset,
   input wire logic msix_enable_cfg,
   input wire logic [2:0] msix_table_bir,
   input wire logic [28:0] msix_table_off,
   input wire logic [2:0] msix_pba_bir,
   input wire logic [28:0] msix_pba_off,
   output logic msix_present,
   output logic [31:0] msix_table_word,
   output logic [31:0] msix_pba_word,
   output logic [63:0] msix_table_addr,
   output logic [63:0] msix_pba_addr,
   output logic msix_bir_error,
   input wire logic d1_support_cfg,
   input wire logic [4:0] pme_support_cfg,
   input wire logic [2:0] power_state,
   input wire logic wake_event,
   output logic power_wake_request,
   output logic [4:0] pme_support_adv,
   output logic d1_support_adv,
   input wire logic [6:0] ext_cap_enable,
   output logic [6:0] ext_cap_present,
   output logic [83:0] ext_cap_offset,
   output logic [83:0] ext_cap_next
);
   // Only the fixed slot and capability counts are served by this logic
   generate
      if (NUM_BAR != sbc_pkg::NUM_BARS)
      begin : g_bad_bar
         $error("NUM_BAR must be six");
      end
      if (NUM_CAP != sbc_pkg::NUM_EXT_CAPS)
      begin : g_bad_cap
         $error("NUM_CAP must be seven");
      end
   endgenerate

   logic [31:0] base_lo_reg [NUM_BAR];
   logic [5:0] slot_usable;
   logic [5:0] slot_upper;
   logic [5:0] slot_hit;
   logic [63:0] slot_off [NUM_BAR];
   logic [63:0] slot_base [NUM_BAR];
   logic [5:0] slot_mem;

   // Minimum aperture for a BAR of the given kind
   function automatic logic [5:0] min_log2(input logic [1:0] t,
                                           input logic leg);
      if (t == sbc_pkg::BAR_TYPE_IO)
      begin
         min_log2 = sbc_pkg::MIN_LOG2_IO;
      end
      else
      begin
         min_log2 = leg ? sbc_pkg::MIN_LOG2_LEGACY
                        : sbc_pkg::MIN_LOG2_NORMAL;
      end
   endfunction

   // Writable base bits above the aperture, used at several places
   function automatic logic [31:0] size_mask(input logic [5:0] l2);
      logic [31:0] m;
      m = 32'hFFFF_FFFF;
      if (l2 < 6'h20)
      begin
         m = 32'hFFFF_FFFF << l2[4:0];
      end
      else
      begin
         m = 32'h0000_0000;
      end
      size_mask = m;
   endfunction

   // Legality of each slot; an upper half of a 64-bit pair never stands alone
   genvar g;
   generate
      for (g = 0; g < NUM_BAR; g++)
      begin : g_slot
         logic [1:0] t;
         logic [5:0] l2;
         logic w64;
         logic ok;
         assign t = bar_type_cfg[2*g +: 2];
         assign l2 = bar_log2_cfg[6*g +: 6];
         assign w64 = bar_is64_cfg[g] && (t == sbc_pkg::BAR_TYPE_MEM)
                      && (g != NUM_BAR - 1);
         if (g == 0)
         begin : g_first
            assign slot_upper[g] = 1'b0;
         end
         else
         begin : g_rest
            assign slot_upper[g] = slot_usable[g-1] && bar_is64_cfg[g-1]
               && (bar_type_cfg[2*g-2 +: 2] == sbc_pkg::BAR_TYPE_MEM);
         end
         always_comb
         begin
            ok = (t != sbc_pkg::BAR_TYPE_NONE) && !slot_upper[g];
            if (l2 < min_log2(t, legacy_ep))
            begin
               ok = 1'b0;
            end
            if (l2 > (w64 ? sbc_pkg::MAX_LOG2_64 : sbc_pkg::MAX_LOG2_32))
            begin
               ok = 1'b0;
            end
            if (t == sbc_pkg::BAR_TYPE_IO && (!legacy_ep || bar_is64_cfg[g]))
            begin
               ok = 1'b0;
            end
            if (!legacy_ep && bar_pref_cfg[g] && !w64 && g != sbc_pkg::LAST_BAR
                && t == sbc_pkg::BAR_TYPE_MEM)
            begin
               ok = 1'b0;
            end
         end
         assign slot_usable[g] = ok;
         assign slot_mem[g] = ok && (t == sbc_pkg::BAR_TYPE_MEM);
         if (g == NUM_BAR - 1)
         begin : g_top
            assign slot_base[g] = {32'h0000_0000,
                                   base_lo_reg[g] & size_mask(l2)};
         end
         else
         begin : g_pair
            assign slot_base[g] = {w64 ? base_lo_reg[g+1] : 32'h0000_0000,
                                   base_lo_reg[g] & size_mask(l2)};
         end
         sbc_bar_decode u_dec
         (
            .bar_type(t),
            .usable(slot_usable[g]),
            .is64(w64),
            .log2_size(l2),
            .base(slot_base[g]),
            .req_addr(req_addr),
            .req_is_io(req_is_io),
            .req_valid(req_valid),
            .hit(slot_hit[g]),
            .offset(slot_off[g])
         );
      end
   endgenerate

   assign bar_legal = slot_usable;

   // Host programs the base registers; only legal slots or upper halves keep it
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < NUM_BAR; i++)
         begin
            base_lo_reg[i] <= sbc_pkg::BAR_RESET;
         end
      end
      else if (bar_wr && bar_wr_idx < 3'(NUM_BAR))
      begin
         if (slot_usable[bar_wr_idx] || slot_upper[bar_wr_idx])
         begin
            base_lo_reg[bar_wr_idx] <= bar_wr_data;
         end
      end
   end

   // Read back with type bits; an unusable slot reads all zero unless it is an upper half, which reads its raw base
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bar_rd_data <= 32'h0000_0000;
      end
      else if (bar_rd_idx >= 3'(NUM_BAR))
      begin
         bar_rd_data <= 32'h0000_0000;
      end
      else if (slot_upper[bar_rd_idx])
      begin
         bar_rd_data <= base_lo_reg[bar_rd_idx];
      end
      else if (!slot_usable[bar_rd_idx])
      begin
         bar_rd_data <= 32'h0000_0000;
      end
      else if (bar_type_cfg[2*bar_rd_idx +: 2] == sbc_pkg::BAR_TYPE_IO)
      begin
         bar_rd_data <= (base_lo_reg[bar_rd_idx]
            & size_mask(bar_log2_cfg[6*bar_rd_idx +: 6]))
            | 32'h0000_0001;
      end
      else
      begin
         bar_rd_data <= (base_lo_reg[bar_rd_idx]
            & size_mask(bar_log2_cfg[6*bar_rd_idx +: 6]))
            | {28'h000_0000, bar_pref_cfg[bar_rd_idx],
               bar_is64_cfg[bar_rd_idx]
               && (bar_rd_idx != 3'(NUM_BAR - 1)), 2'h0};
      end
   end

   // Lowest hitting slot wins; legal windows never overlap in practice
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         req_hit <= 1'b0;
         req_bar <= 3'h0;
         req_offset <= 64'h0000_0000_0000_0000;
      end
      else
      begin
         req_hit <= |slot_hit;
         req_bar <= 3'h0;
         req_offset <= 64'h0000_0000_0000_0000;
         for (int i = NUM_BAR - 1; i >= 0; i--)
         begin
            if (slot_hit[i])
            begin
               req_bar <= 3'(i);
               req_offset <= slot_off[i];
            end
         end
      end
   end

   // MSI-X placement; indicators must name a usable lower memory slot
   logic tbl_ok;
   logic pba_ok;
   always_comb
   begin
      tbl_ok = msix_table_bir < 3'(NUM_BAR)
               && slot_mem[msix_table_bir];
      pba_ok = msix_pba_bir < 3'(NUM_BAR) && slot_mem[msix_pba_bir];
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         msix_present <= 1'b0;
         msix_bir_error <= 1'b0;
         msix_table_word <= 32'h0000_0000;
         msix_pba_word <= 32'h0000_0000;
         msix_table_addr <= 64'h0000_0000_0000_0000;
         msix_pba_addr <= 64'h0000_0000_0000_0000;
      end
      else
      begin
         msix_present <= msix_enable_cfg && (|slot_mem);
         msix_bir_error <= msix_enable_cfg && !(tbl_ok && pba_ok);
         msix_table_word <= {msix_table_off, msix_table_bir};
         msix_pba_word <= {msix_pba_off, msix_pba_bir};
         msix_table_addr <= tbl_ok ? slot_base[msix_table_bir]
            + {32'h0000_0000, msix_table_off, 3'h0}
            : 64'h0000_0000_0000_0000;
         msix_pba_addr <= pba_ok ? slot_base[msix_pba_bir]
            + {32'h0000_0000, msix_pba_off, 3'h0}
            : 64'h0000_0000_0000_0000;
      end
   end

   // Power management advertisement and wake request, registered on the system clock
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         d1_support_adv <= 1'b0;
         pme_support_adv <= 5'h00;
         power_wake_request <= 1'b0;
      end
      else
      begin
         d1_support_adv <= d1_support_cfg;
         pme_support_adv <= pme_support_cfg
            & ~(d1_support_cfg ? 5'h00 : 5'h02);
         power_wake_request <= wake_event
            && power_state < 3'(sbc_pkg::NUM_PSTATES)
            && pme_support_cfg[power_state]
            && (power_state != 3'(sbc_pkg::PSTATE_D1)
                || d1_support_cfg);
      end
   end

   // Capability list: slot 0 is the error reporting one, always on
   logic [6:0] cap_on;
   assign cap_on = ext_cap_enable | 7'h01;
   generate
      for (g = 0; g < NUM_CAP; g++)
      begin : g_cap
         logic [11:0] nxt;
         always_comb
         begin
            nxt = 12'h000;
            for (int j = NUM_CAP - 1; j > g; j--)
            begin
               if (cap_on[j])
               begin
                  nxt = sbc_pkg::AER_OFFSET
                        + 12'(j) * sbc_pkg::EXT_CAP_STRIDE;
               end
            end
         end
         always_ff @(posedge sys_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               ext_cap_next[12*g +: 12] <= 12'h000;
               ext_cap_offset[12*g +: 12] <= 12'h000;
               ext_cap_present[g] <= 1'b0;
            end
            else
            begin
               ext_cap_present[g] <= cap_on[g];
               ext_cap_offset[12*g +: 12] <= cap_on[g]
                  ? sbc_pkg::AER_OFFSET + 12'(g) * sbc_pkg::EXT_CAP_STRIDE
                  : 12'h000;
               ext_cap_next[12*g +: 12] <= cap_on[g] ? nxt : 12'h000;
            end
         end
      end
   endgenerate
endmodule

// ===== test/sbc_core_checker.sv
// Port-level assertions for the BAR and capability block
module sbc_core_checker
#(
   parameter int NUM_BAR = 6,
   parameter int NUM_CAP = 7
)
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic legacy_ep,
   input wire logic [11:0] bar_type_cfg,
   input wire logic [5:0] bar_is64_cfg,
   input wire logic [5:0] bar_pref_cfg,
   input wire logic [35:0] bar_log2_cfg,
   input wire logic [2:0] bar_rd_idx,
   input wire logic [31:0] bar_rd_data,
   input wire logic [5:0] bar_legal,
   input wire logic req_valid,
   input wire logic req_is_io,
   input wire logic req_hit,
   input wire logic [2:0] req_bar,
   input wire logic msix_enable_cfg,
   input wire logic [2:0] msix_table_bir,
   input wire logic msix_bir_error,
   input wire logic [4:0] pme_support_cfg,
   input wire logic [2:0] power_state,
   input wire logic wake_event,
   input wire logic power_wake_request,
   input wire logic [6:0] ext_cap_present,
   input wire logic [83:0] ext_cap_offset
);
   // Everything is judged on the one system clock, quiet in reset
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   io_miss_a:
   assert property (req_valid && req_is_io && !legacy_ep |=> !req_hit)
      else $error("io request hit on a normal endpoint");
   hit_legal_a:
   assert property (req_hit |-> ($past(bar_legal) >> req_bar) & 6'h01)
      else $error("hit reported on an unusable slot");
   pref_wide_a:
   assert property (!legacy_ep && bar_type_cfg[9:8] == sbc_pkg::BAR_TYPE_MEM
      && bar_pref_cfg[4] && !bar_is64_cfg[4] |-> !bar_legal[4])
      else $error("narrow prefetchable slot accepted");
   min_size_a:
   assert property (bar_type_cfg[5:4] == sbc_pkg::BAR_TYPE_MEM
      && bar_log2_cfg[17:12] < (legacy_ep ? sbc_pkg::MIN_LOG2_LEGACY
      : sbc_pkg::MIN_LOG2_NORMAL) |-> !bar_legal[2])
      else $error("undersized window accepted");
   max_size_a:
   assert property (bar_type_cfg[7:6] == sbc_pkg::BAR_TYPE_MEM
      && !bar_is64_cfg[3] && bar_log2_cfg[23:18] > sbc_pkg::MAX_LOG2_32
      |-> !bar_legal[3])
      else $error("oversized narrow window accepted");
   upper_half_a:
   assert property (bar_type_cfg[1:0] == sbc_pkg::BAR_TYPE_MEM
      && bar_is64_cfg[0] && bar_legal[0] |-> !bar_legal[1])
      else $error("upper half of a wide pair usable");
   wake_state_a:
   assert property (power_wake_request |-> $past(wake_event)
      && ($past(pme_support_cfg) >> $past(power_state)) & 5'h01)
      else $error("wake raised in a state without wake support");
   aer_fixed_a:
   assert property ($past(rst_n) |-> ext_cap_present[0]
      && ext_cap_offset[11:0] == sbc_pkg::AER_OFFSET)
      else $error("error reporting capability missing or moved");
   bir_upper_a:
   assert property (msix_enable_cfg && msix_table_bir == 3'h1
      && bar_is64_cfg[0] && bar_legal[0] |=> msix_bir_error)
      else $error("indicator naming an upper half not flagged");
   off_reads_a:
   assert property (bar_rd_idx == 3'h3 && !bar_legal[3] && !bar_is64_cfg[2]
      |=> bar_rd_data == 32'h0000_0000)
      else $error("unusable slot reads nonzero");

   // Main scenarios reached
   cover property (req_hit && req_bar == 3'h5);
   cover property (msix_bir_error);
   cover property (power_wake_request);
endmodule

bind sbc_core sbc_core_checker #(.NUM_BAR(NUM_BAR), .NUM_CAP(NUM_CAP))
   watch (.*);

// ===== test/sbc_host_model.sv
// Host model that programs BAR bases and issues decode requests
module sbc_host_model
(
   input wire logic sys_clk,
   output logic bar_wr,
   output logic [2:0] bar_wr_idx,
   output logic [31:0] bar_wr_data,
   output logic req_valid,
   output logic req_is_io,
   output logic [63:0] req_addr
);
   timeunit 1ns;
   timeprecision 1ns;

   // Quiet bus at time zero
   initial
   begin
      bar_wr = 1'b0;
      bar_wr_idx = 3'h0;
      bar_wr_data = 32'h0000_0000;
      req_valid = 1'b0;
      req_is_io = 1'b0;
      req_addr = 64'h0000_0000_0000_0000;
   end

   // Whole doubleword write, held for exactly one sampling edge
   task automatic wr_base(input logic [2:0] idx, input logic [31:0] data);
      @(posedge sys_clk);
      #2;
      bar_wr = 1'b1;
      bar_wr_idx = idx;
      bar_wr_data = data;
      @(posedge sys_clk);
      #2;
      bar_wr = 1'b0;
      bar_wr_data = ~data; // Stale data must never look valid
   endtask

   // Request stays up until idle, so back-to-back calls are allowed
   task automatic issue(input logic io, input logic [63:0] addr);
      @(posedge sys_clk);
      #2;
      req_valid = 1'b1;
      req_is_io = io;
      req_addr = addr;
   endtask

   task automatic idle();
      req_valid = 1'b0;
      req_addr = ~req_addr;
   endtask
endmodule

// ===== test/test_sriov_bar_capability_config.sv
// Self-checking bench for the BAR and capability block
module test_sriov_bar_capability_config;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {
      logic [2:0] idx;
      logic [31:0] rd;
      logic io;
      logic [63:0] addr;
      logic hit;
      logic [2:0] bar;
      logic [63:0] off;
   } sbc_row_type;
   logic sys_clk, rst_n, legacy_ep, msix_enable_cfg, d1_support_cfg;
   logic wake_event, bar_wr, req_valid, req_is_io, req_hit, msix_present;
   logic msix_bir_error, power_wake_request, d1_support_adv;
   logic [11:0] bar_type_cfg;
   logic [5:0] bar_is64_cfg, bar_pref_cfg, bar_legal;
   logic [35:0] bar_log2_cfg;
   logic [2:0] bar_rd_idx, msix_table_bir, msix_pba_bir, power_state;
   logic [2:0] bar_wr_idx, req_bar;
   logic [28:0] msix_table_off, msix_pba_off;
   logic [4:0] pme_support_cfg, pme_support_adv;
   logic [6:0] ext_cap_enable, ext_cap_present;
   logic [31:0] bar_wr_data, bar_rd_data, msix_table_word, msix_pba_word;
   logic [63:0] req_addr, req_offset, msix_table_addr, msix_pba_addr;
   logic [83:0] ext_cap_offset, ext_cap_next;
   int n_mismatch = 0;
   int comparisons = 0;
   int cycles = 0;
   logic [31:0] bases [6] = '{32'h1000_0000, 32'h0000_0002, 32'h2000_0000,
      32'h4000_0000, 32'h5000_0000, 32'h3000_0000};
   // Slot 0 wide at 0x2_1000_0000, slot 2 of 128 bytes, 3 and 4 unusable
   sbc_row_type rows [6] = '{
      '{3'h0, 32'h1000_000C, 1'b0, 64'h0000_0002_1000_0010, 1'b1, 3'h0, 64'h10},
      '{3'h1, 32'h0000_0002, 1'b0, 64'h0000_0002_1000_1000, 1'b0, 3'h0, 64'h0},
      '{3'h2, 32'h2000_0000, 1'b0, 64'h0000_0000_2000_007C, 1'b1, 3'h2, 64'h7C},
      '{3'h3, 32'h0000_0000, 1'b1, 64'h0000_0000_2000_0010, 1'b0, 3'h0, 64'h0},
      '{3'h4, 32'h0000_0000, 1'b0, 64'h0000_0000_2000_0080, 1'b0, 3'h0, 64'h0},
      '{3'h5, 32'h3000_0008, 1'b0, 64'h0000_0000_3000_0FFF, 1'b1, 3'h5, 64'hFFF}};
   logic [6:0] ext_sets [3] = '{7'h00, 7'h54, 7'h7E};

   sbc_core dut (.*);
   sbc_host_model host (.*);

   task automatic chk(input string what, input logic [83:0] exp,
      input logic [83:0] got);
      comparisons++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic conclude();
      if (n_mismatch == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Expected list worked out walking down from the highest capability
   task automatic ext_check(input logic [6:0] en);
      logic [6:0] p;
      logic [83:0] eo;
      logic [83:0] en_next;
      logic [11:0] nxt;
      p = en | 7'h01;
      nxt = 12'h000;
      for (int i = 6; i >= 0; i--)
      begin
         eo[12*i+:12] = p[i] ? 12'(12'h100 + 12'h040 * i) : 12'h000;
         en_next[12*i+:12] = p[i] ? nxt : 12'h000;
         if (p[i])
            nxt = eo[12*i+:12];
      end
      ext_cap_enable = en;
      @(posedge sys_clk);
      #2;
      chk("cap present", p, ext_cap_present);
      chk("cap offset", eo, ext_cap_offset);
      chk("cap next", en_next, ext_cap_next);
   endtask

   // Clock of 20 ns period
   initial
   begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // A hang counts as a mismatch
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         n_mismatch++;
         conclude();
      end
   end

   // Directed run: legality, sizing and table rows, then MSI-X, wake and capability checks, then reset and the awkward cases
   initial
   begin
      rst_n = 1'b0;
      legacy_ep = 1'b0;
      bar_type_cfg = 12'h591;
      bar_is64_cfg = 6'h01;
      bar_pref_cfg = 6'h31;
      bar_log2_cfg = {6'h0C, 6'h0C, 6'h04, 6'h07, 6'h00, 6'h0C};
      bar_rd_idx = 3'h0;
      msix_enable_cfg = 1'b1;
      msix_table_bir = 3'h0;
      msix_table_off = 29'h000_0002;
      msix_pba_bir = 3'h2;
      msix_pba_off = 29'h000_0001;
      d1_support_cfg = 1'b0;
      pme_support_cfg = 5'h1B;
      power_state = 3'h0;
      wake_event = 1'b1;
      ext_cap_enable = 7'h00;
      repeat (8) @(posedge sys_clk);
      #2;
      rst_n = 1'b1;
      chk("legal", 6'h25, bar_legal);
      host.wr_base(3'h2, 32'hFFFF_FFFF);
      bar_rd_idx = 3'h2;
      @(posedge sys_clk);
      #2;
      chk("sizing", 32'hFFFF_FF80, bar_rd_data);
      for (int i = 0; i < 6; i++)
         host.wr_base(i[2:0], bases[i]);
      foreach (rows[i])
      begin
         host.issue(rows[i].io, rows[i].addr);
         bar_rd_idx = rows[i].idx;
         @(posedge sys_clk);
         #2;
         chk("readback", rows[i].rd, bar_rd_data);
         chk("hit", rows[i].hit, req_hit);
         if (rows[i].hit)
         begin
            chk("bar", rows[i].bar, req_bar);
            chk("offset", rows[i].off, req_offset);
         end
      end
      host.idle();
      chk("msix", 1'b1, msix_present);
      chk("table word", 32'h0000_0010, msix_table_word);
      chk("pba word", 32'h0000_000A, msix_pba_word);
      chk("table addr", 64'h0000_0002_1000_0010, msix_table_addr);
      chk("pba addr", 64'h0000_0000_2000_0008, msix_pba_addr);
      chk("bir err", 1'b0, msix_bir_error);
      msix_table_bir = 3'h1;
      @(posedge sys_clk);
      #2;
      chk("bir err", 1'b1, msix_bir_error);
      chk("table addr", 64'h0, msix_table_addr);
      for (int d = 0; d < 2; d++)
         for (int st = 0; st < 5; st++)
         begin
            d1_support_cfg = d[0];
            power_state = st[2:0];
            @(posedge sys_clk);
            #2;
            chk("wake", pme_support_cfg[st] && (st != 1 || d == 1),
               power_wake_request);
            chk("pme adv", d ? 5'h1B : 5'h19, pme_support_adv);
            chk("d1 adv", d[0], d1_support_adv);
         end
      wake_event = 1'b0;
      foreach (ext_sets[k])
         ext_check(ext_sets[k]);
      chk("no wake", 1'b0, power_wake_request);
      // Second reset mid-run, then a legacy endpoint with an I/O window
      rst_n = 1'b0;
      legacy_ep = 1'b1;
      bar_type_cfg = 12'h156;
      bar_is64_cfg = 6'h10;
      bar_pref_cfg = 6'h02;
      bar_log2_cfg = {6'h00, 6'h21, 6'h20, 6'h03, 6'h04, 6'h04};
      #2;
      chk("rst hit", 1'b0, req_hit);
      chk("rst read", 32'h0000_0000, bar_rd_data);
      chk("legacy legal", 6'h13, bar_legal);
      @(posedge sys_clk);
      #2;
      legacy_ep = 1'b0;
      @(posedge sys_clk);
      #2;
      chk("normal legal", 6'h10, bar_legal);
      legacy_ep = 1'b1;
      @(posedge sys_clk);
      #2;
      rst_n = 1'b1;
      host.wr_base(3'h0, 32'h0000_1000);
      bar_rd_idx = 3'h0;
      host.issue(1'b1, 64'h0000_0000_0000_1008);
      @(posedge sys_clk);
      #2;
      chk("io read", 32'h0000_1001, bar_rd_data);
      chk("io hit", 1'b1, req_hit);
      chk("io offset", 64'h8, req_offset);
      host.issue(1'b0, 64'h0000_0000_0000_1008);
      @(posedge sys_clk);
      #2;
      chk("mem hit", 1'b1, req_hit);
      chk("mem bar", 3'h4, req_bar);
      host.idle();
      bar_type_cfg = 12'h000;
      @(posedge sys_clk);
      #2;
      chk("msix no bar", 1'b0, msix_present);
      conclude();
   end
endmodule
